//--- hdl/wd_consts.vh
// constants for the watchdog timer control block
// assumes a 32-bit classic wishbone slave with byte addresses
`ifndef WD_CONSTS_VH
`define WD_CONSTS_VH

// register byte offsets
`define WD_ADR_CTRL 8'h00
`define WD_ADR_CAUSE 8'h04
`define WD_ADR_STATUS 8'h08
`define WD_ADR_MASK 8'h0c
`define WD_ADR_STATE 8'h10

// watchdog_control field positions
`define WD_BIT_IRQ_FLAG 7
`define WD_BIT_IRQ_ENABLE 6
`define WD_BIT_PRESCALE_HI 5
`define WD_BIT_CHANGE_ENABLE 4
`define WD_BIT_RESET_ENABLE 3
`define WD_CTRL_RESET 8'h00

// reset_cause_register field position
`define WD_BIT_RESET_FLAG 3

// event status bits (status and mask share the layout)
`define WD_EV_TIMEOUT 0
`define WD_EV_RESET 1
`define WD_EV_W 2
`define WD_EV_RESET_VAL 2'h0

// modes as {reset enable, irq enable}
`define WD_MODE_STOP 2'h0
`define WD_MODE_IRQ 2'h1
`define WD_MODE_RESET 2'h2
`define WD_MODE_BOTH 2'h3

// timing: change window in main clock cycles, period in oscillator cycles
`define WD_CE_CYCLES 3'h4
`define WD_PRESCALE_MAX 4'h9
`define WD_BASE_PERIOD 21'h000800
`define WD_CNT_W 20

// program addresses of the reset and watchdog vectors
`define WD_RESET_VECTOR 16'h0000
`define WD_IRQ_VECTOR 16'h0008

`endif

//--- hdl/wd_osc_counter.v
// counts cycles of the watchdog oscillator and flags the time-out
// assumes wd_osc is a free running pin far slower than clk
`timescale 1ns/1ps
`default_nettype none
`include "wd_consts.vh"

module wd_osc_counter (
   input wire clk,
   input wire nrst,
   input wire wd_osc,
   input wire run,
   input wire restart,
   input wire [3:0] sel,
   output reg timeout,
   output reg [19:0] count
);

////////////////////////////////////////////////////////////////////////
// reserved codes fall back to the longest period
function [19:0] last_count;
   input [3:0] s;
   reg [3:0] c;
   reg [20:0] p;
   begin
      c = (s > `WD_PRESCALE_MAX) ? `WD_PRESCALE_MAX : s;
      p = (`WD_BASE_PERIOD << c) - 21'h000001;
      last_count = p[19:0];
   end
endfunction

reg osc_meta;
reg osc_sync;
reg osc_prev;
wire tick;

////////////////////////////////////////////////////////////////////////
// oscillator crosses by two flops before the edge detector
always @(posedge clk) begin
   if (!nrst) begin
      osc_meta <= 1'b0;
      osc_sync <= 1'b0;
      osc_prev <= 1'b0;
   end else begin
      osc_meta <= wd_osc;
      osc_sync <= osc_meta;
      osc_prev <= osc_sync;
   end
end

assign tick = osc_sync & ~osc_prev;

////////////////////////////////////////////////////////////////////////
// >= so a switch to a shorter period times out at the next oscillator tick, not after a wrap
always @(posedge clk) begin
   if (!nrst) begin
      count <= 20'h00000;
      timeout <= 1'b0;
   end else if (restart || !run) begin
      count <= 20'h00000;
      timeout <= 1'b0;
   end else if (tick && count >= last_count(sel)) begin
      count <= 20'h00000;
      timeout <= 1'b1;
   end else begin
      count <= tick ? count + 20'h00001 : count;
      timeout <= 1'b0;
   end
end

endmodule // wd_osc_counter
`default_nettype wire

//--- hdl/watchdog_timer_control.v
// watchdog timer control: control register, mode logic, reset and
// interrupt requests, reached over a classic wishbone slave
// assumes the cpu core drives restart, vector-taken and the global
// interrupt bit on clk; the fuse and the oscillator are pins
`timescale 1ns/1ps
`default_nettype none
`include "wd_consts.vh"

module watchdog_timer_control (
   input wire clk,
   input wire nrst,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   input wire wd_osc,
   input wire wd_always_on_fuse,
   input wire global_irq_enable,
   input wire wd_restart,
   input wire wd_vector_taken,
   output reg wd_irq_req,
   output reg [15:0] wd_irq_vector,
   output reg sys_reset_req,
   output reg [15:0] reset_vector,
   output reg irq
);

////////////////////////////////////////////////////////////////////////
// declarations

reg wd_irq_flag;
reg wd_irq_enable;
reg wd_reset_enable;
reg wd_change_enable;
reg [3:0] wd_prescale_sel;
reg [2:0] ce_timer;
reg wd_reset_flag;
reg fuse_meta;
reg fuse_sync;
reg [`WD_EV_W-1:0] irq_status;
reg [`WD_EV_W-1:0] irq_mask;
reg [`WD_EV_W-1:0] next_status;
reg [31:0] next_rdata;

wire req;
wire wr;
wire rd;
wire ctrl_wr;
wire cause_wr;
wire mask_wr;
wire status_rd;
wire fuse_prog;
wire reset_en_eff;
wire irq_en_eff;
wire [1:0] mode;
wire run;
wire timeout;
wire [19:0] count;
wire set_flag;
wire do_reset;
wire [7:0] ctrl_view;
wire [3:0] din_prescale;
wire [`WD_EV_W-1:0] events;

////////////////////////////////////////////////////////////////////////
// bus decode: one request per ack, ack never stands two cycles

// full 8-bit compare, so aliases of a register never answer as it
function adr_hit;
   input [7:0] a;
   input [7:0] target;
   begin
      adr_hit = (a == target);
   end
endfunction

assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
assign wr = req & wb_we_i & wb_sel_i[0];
assign rd = req & ~wb_we_i;
assign ctrl_wr = wr & adr_hit(wb_adr_i, `WD_ADR_CTRL);
assign cause_wr = wr & adr_hit(wb_adr_i, `WD_ADR_CAUSE);
assign mask_wr = wr & adr_hit(wb_adr_i, `WD_ADR_MASK);
assign status_rd = rd & adr_hit(wb_adr_i, `WD_ADR_STATUS);

assign din_prescale = {wb_dat_i[`WD_BIT_PRESCALE_HI], wb_dat_i[2:0]};

////////////////////////////////////////////////////////////////////////
// fuse pin synchroniser; resets to programmed so the block starts safe

always @(posedge clk) begin
   if (!nrst) begin
      fuse_meta <= 1'b0;
      fuse_sync <= 1'b0;
   end else begin
      fuse_meta <= wd_always_on_fuse;
      fuse_sync <= fuse_meta;
   end
end

assign fuse_prog = ~fuse_sync;

////////////////////////////////////////////////////////////////////////
// mode selection

// reset flag and the fuse both hold the reset enable high
assign reset_en_eff = wd_reset_enable | wd_reset_flag | fuse_prog;
assign irq_en_eff = wd_irq_enable & ~fuse_prog;
assign mode = {reset_en_eff, irq_en_eff};
assign run = (mode != `WD_MODE_STOP);

////////////////////////////////////////////////////////////////////////
// oscillator counter

wd_osc_counter u_counter (
   .clk(clk),
   .nrst(nrst),
   .wd_osc(wd_osc),
   .run(run),
   .restart(wd_restart),
   .sel(wd_prescale_sel),
   .timeout(timeout),
   .count(count)
);

////////////////////////////////////////////////////////////////////////
// time-out actions

// interrupt only: every time-out sets the flag; combined: the first one
// sets it and a second one while it is still set resets the system
assign set_flag = timeout & irq_en_eff & ~(reset_en_eff & wd_irq_flag);
assign do_reset = timeout & reset_en_eff & (~irq_en_eff | wd_irq_flag);

assign events = {do_reset, timeout};

////////////////////////////////////////////////////////////////////////
// interrupt flag: a time-out in the clearing cycle still sets it, unless that time-out resets the system instead

always @(posedge clk) begin
   if (!nrst) begin
      wd_irq_flag <= 1'b0;
   end else if (set_flag) begin
      wd_irq_flag <= 1'b1;
   end else if (wd_vector_taken) begin
      wd_irq_flag <= 1'b0;
   end else if (ctrl_wr && wb_dat_i[`WD_BIT_IRQ_FLAG]) begin
      wd_irq_flag <= 1'b0;
   end
end

////////////////////////////////////////////////////////////////////////
// interrupt enable; re-arming it is left to software

always @(posedge clk) begin
   if (!nrst) begin
      wd_irq_enable <= 1'b0;
   end else if (fuse_prog) begin
      wd_irq_enable <= 1'b0;
   end else if (wd_vector_taken && reset_en_eff) begin
      wd_irq_enable <= 1'b0;
   end else if (ctrl_wr) begin
      wd_irq_enable <= wb_dat_i[`WD_BIT_IRQ_ENABLE];
   end
end

////////////////////////////////////////////////////////////////////////
// reset enable: setting is always allowed, clearing needs the window

always @(posedge clk) begin
   if (!nrst) begin
      wd_reset_enable <= 1'b0;
   end else if (wd_reset_flag) begin
      // the fuse lock acts through reset_en_eff only: storing it here would
      // keep the bit set after the synchroniser's programmed reset value
      wd_reset_enable <= 1'b1;
   end else if (ctrl_wr && wb_dat_i[`WD_BIT_RESET_ENABLE]) begin
      wd_reset_enable <= 1'b1;
   end else if (ctrl_wr && wd_change_enable) begin
      wd_reset_enable <= 1'b0;
   end
end

////////////////////////////////////////////////////////////////////////
// prescaler; stored as written, reserved codes are clamped in the counter

always @(posedge clk) begin
   if (!nrst) begin
      wd_prescale_sel <= 4'h0;
   end else if (ctrl_wr && wd_change_enable) begin
      wd_prescale_sel <= din_prescale;
   end
end

////////////////////////////////////////////////////////////////////////
// change window: opened only by writing change and reset enable together

always @(posedge clk) begin
   if (!nrst) begin
      wd_change_enable <= 1'b0;
      ce_timer <= 3'h0;
   end else if (ctrl_wr && wb_dat_i[`WD_BIT_CHANGE_ENABLE]
                && wb_dat_i[`WD_BIT_RESET_ENABLE]) begin
      wd_change_enable <= 1'b1;
      ce_timer <= `WD_CE_CYCLES;
   end else if (ctrl_wr && !wb_dat_i[`WD_BIT_CHANGE_ENABLE]) begin
      wd_change_enable <= 1'b0;
      ce_timer <= 3'h0;
   end else if (ce_timer == 3'h1) begin
      wd_change_enable <= 1'b0;
      ce_timer <= 3'h0;
   end else if (ce_timer != 3'h0) begin
      ce_timer <= ce_timer - 3'h1;
   end
end

////////////////////////////////////////////////////////////////////////
// reset cause: set by a watchdog reset, cleared by writing zero;
// only nrst (power-on) clears it otherwise

always @(posedge clk) begin
   if (!nrst) begin
      wd_reset_flag <= 1'b0;
   end else if (do_reset) begin
      wd_reset_flag <= 1'b1;
   end else if (cause_wr && !wb_dat_i[`WD_BIT_RESET_FLAG]) begin
      wd_reset_flag <= 1'b0;
   end
end

////////////////////////////////////////////////////////////////////////
// requests to the core

always @(posedge clk) begin
   if (!nrst) begin
      sys_reset_req <= 1'b0;
      wd_irq_req <= 1'b0;
      reset_vector <= `WD_RESET_VECTOR;
      wd_irq_vector <= `WD_IRQ_VECTOR;
   end else begin
      sys_reset_req <= do_reset;
      // flag, enable and the global bit all needed
      wd_irq_req <= wd_irq_flag & irq_en_eff & global_irq_enable & ~wd_vector_taken;
      reset_vector <= `WD_RESET_VECTOR;
      wd_irq_vector <= `WD_IRQ_VECTOR;
   end
end

////////////////////////////////////////////////////////////////////////
// event status, cleared by reading it; a new event wins over the clear

always @* begin
   next_status = irq_status;
   if (status_rd) begin
      next_status = {`WD_EV_W{1'b0}};
   end
   next_status = next_status | events;
end

always @(posedge clk) begin
   if (!nrst) begin
      irq_status <= `WD_EV_RESET_VAL;
      irq_mask <= `WD_EV_RESET_VAL;
      irq <= 1'b0;
   end else begin
      irq_status <= next_status;
      if (mask_wr) begin
         irq_mask <= wb_dat_i[`WD_EV_W-1:0];
      end
      irq <= |(irq_status & irq_mask);
   end
end

////////////////////////////////////////////////////////////////////////
// read mux

// control reads the effective reset enable, so a forced one is visible
assign ctrl_view = {wd_irq_flag, irq_en_eff, wd_prescale_sel[3], wd_change_enable,
                    reset_en_eff, wd_prescale_sel[2:0]};

always @* begin
   next_rdata = 32'h00000000;
   case (wb_adr_i)
      `WD_ADR_CTRL: begin
         next_rdata[7:0] = ctrl_view;
      end
      `WD_ADR_CAUSE: begin
         next_rdata[`WD_BIT_RESET_FLAG] = wd_reset_flag;
      end
      `WD_ADR_STATUS: begin
         next_rdata[`WD_EV_W-1:0] = irq_status;
      end
      `WD_ADR_MASK: begin
         next_rdata[`WD_EV_W-1:0] = irq_mask;
      end
      `WD_ADR_STATE: begin
         next_rdata[19:0] = count;
         next_rdata[21:20] = mode;
         next_rdata[22] = run;
      end
      default: begin
         next_rdata = 32'h00000000;
      end
   endcase
end

////////////////////////////////////////////////////////////////////////
// bus answer: ack one cycle after the request, every address answers

always @(posedge clk) begin
   if (!nrst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
   end else begin
      wb_ack_o <= req;
      if (rd) begin
         wb_dat_o <= next_rdata;
      end
   end
end

endmodule // watchdog_timer_control
`default_nettype wire

//--- test/wd_checker_assertions.sv
// checker: bus timing and request outputs of the watchdog block
// assumes it is bound to watchdog_timer_control and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module wd_checker (
   input wire clk,
   input wire nrst,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [31:0] wb_dat_o,
   input wire wb_ack_o,
   input wire wd_always_on_fuse,
   input wire global_irq_enable,
   input wire wd_vector_taken,
   input wire wd_irq_req,
   input wire [15:0] wd_irq_vector,
   input wire sys_reset_req,
   input wire [15:0] reset_vector
);
   default clocking dc @(posedge clk);
   endclocking
   default disable iff (!nrst);
   ////////////////////////////////////////////////////////////
   a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not acknowledged in the next cycle");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_unmapped_zero: assert property (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) > 8'h10 |-> wb_dat_o == 32'h0)
      else $error("unmapped read not zero");
   a_vector_fixed: assert property (wd_irq_vector == 16'h0008 && reset_vector == 16'h0000)
      else $error("vector address wrong");
   a_irq_gated: assert property (wd_irq_req |-> $past(global_irq_enable))
      else $error("interrupt request without global enable");
   a_vector_clears: assert property (wd_vector_taken |=> !wd_irq_req)
      else $error("interrupt request after vector taken");
   a_reset_single: assert property (sys_reset_req |=> !sys_reset_req)
      else $error("reset request longer than one cycle");
   // fuse passes two sync flops, so it must have been low for a while
   a_fuse_lock: assert property (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == 8'h00
      && !$past(wd_always_on_fuse, 2) && !$past(wd_always_on_fuse, 3) && !$past(wd_always_on_fuse, 4)
      |-> wb_dat_o[3] && !wb_dat_o[6])
      else $error("fuse does not lock the enables");
endmodule // wd_checker
bind watchdog_timer_control wd_checker i_wd_checker (.clk, .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
   .wb_dat_o, .wb_ack_o, .wd_always_on_fuse, .global_irq_enable, .wd_vector_taken, .wd_irq_req,
   .wd_irq_vector, .sys_reset_req, .reset_vector);
`default_nettype wire

//--- test/tb_top.sv
// testbench: drives the watchdog block over wishbone and its cpu pins
// assumes the design files come first; the oscillator pin is made here
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk = 0, nrst = 0, cyc = 0, stb = 0, we = 0, fuse = 1, gie = 1, rs = 0, vt = 0;
   logic [7:0] adr = 0;
   logic [3:0] sel = 0;
   wire [15:0] ivec, rvec;
   logic [31:0] dat = 0, q;
   logic [1:0] div = 0;
   wire [31:0] rdat;
   wire ack, irq_req, rst_req, irq;
   int n_errors = 0, checked = 0, n;
   always #5 clk = ~clk;
   // fast oscillator: one tick every 4 clocks keeps 2048 ticks short
   always @(posedge clk) div <= div + 2'h1;
   watchdog_timer_control i_watchdog_timer_control (.clk(clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .wd_osc(div[1]), .wd_always_on_fuse(fuse), .global_irq_enable(gie), .wd_restart(rs),
      .wd_vector_taken(vt), .wd_irq_req(irq_req), .wd_irq_vector(ivec), .sys_reset_req(rst_req),
      .reset_vector(rvec), .irq(irq));
   ////////////////////////////////////////////////////////////
   task automatic close_out;
      $display("errors %0d, checks %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   // four clocks per oscillator tick; reserved codes act as the longest period
   function automatic int clks_for(input logic [3:0] code);
      return 4 * (2048 << ((code > 4'h9) ? 4'h9 : code));
   endfunction
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
      int k;
      @(posedge clk);
      cyc <= 1;
      stb <= 1;
      we <= w;
      sel <= 4'hf;
      adr <= a;
      dat <= d;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (ack !== 1'b1 && k < 20);
      // a missing ack counts as a mismatch instead of returning quietly
      cmp(ack, 1);
      q = rdat;
      cyc <= 0;
      stb <= 0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      bus(a, 0, 0);
      cmp(q, e);
   endtask
   task automatic pulse(input logic v);
      @(posedge clk);
      vt <= v;
      rs <= !v;
      @(posedge clk);
      vt <= 0;
      rs <= 0;
   endtask
   task automatic wait_hi(input logic s);
      n = 0;
      while ((s ? rst_req : irq_req) !== 1'b1 && n < 9000) begin
         @(posedge clk);
         n++;
      end
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(32'h5487e6da));
      repeat (16) @(posedge clk);
      nrst <= 1;
      repeat (3) @(posedge clk);
      rd(8'h00, 32'h00);
      rd(8'h10, 32'h00);
      cmp(ivec, 32'h0008);
      cmp(rvec, 32'h0000);
      bus(8'h14, 1, $urandom);
      rd(8'h14, 32'h00);
      bus(8'h0c, 1, 32'h01);
      rd(8'h0c, 32'h01);
      bus(8'h00, 1, 32'h40);
      repeat (3) begin
         repeat ($urandom_range(5000, 1000)) @(posedge clk);
         pulse(0);
         cmp(irq_req, 0);
      end
      wait_hi(0);
      cmp(irq_req, 1);
      cmp(n > clks_for(4'h0) - 16 && n < clks_for(4'h0) + 16, 1);
      gie <= 0;
      repeat (2) @(posedge clk);
      cmp(irq_req, 0);
      cmp(irq, 1);
      gie <= 1;
      rd(8'h08, 32'h01);
      rd(8'h08, 32'h00);
      @(posedge clk);
      cmp(irq, 0);
      rd(8'h00, 32'hc0);
      bus(8'h00, 1, 32'hc0);
      rd(8'h00, 32'h40);
      cmp(irq_req, 0);
      bus(8'h00, 1, 32'h41);
      rd(8'h00, 32'h40);
      bus(8'h00, 1, 32'h58);
      bus(8'h00, 1, 32'h40);
      rd(8'h00, 32'h40);
      bus(8'h00, 1, 32'h58);
      rd(8'h00, 32'h58);
      bus(8'h00, 1, 32'h40);
      rd(8'h00, 32'h48);
      wait_hi(0);
      cmp(irq_req, 1);
      rd(8'h00, 32'hc8);
      wait_hi(1);
      cmp(rst_req, 1);
      rd(8'h04, 32'h08);
      rd(8'h08, 32'h03);
      pulse(1);
      rd(8'h00, 32'h08);
      bus(8'h00, 1, 32'h48);
      rd(8'h00, 32'h48);
      bus(8'h00, 1, 32'h18);
      bus(8'h00, 1, 32'h00);
      rd(8'h00, 32'h08);
      bus(8'h04, 1, 32'h00);
      rd(8'h04, 32'h00);
      bus(8'h00, 1, 32'h18);
      bus(8'h00, 1, 32'h00);
      rd(8'h00, 32'h00);
      fuse <= 0;
      repeat (4) @(posedge clk);
      bus(8'h00, 1, 32'h40);
      rd(8'h00, 32'h08);
      bus(8'h10, 0, 0);
      cmp(q[21:20], 2'h2);
      wait_hi(1);
      cmp(rst_req, 1);
      close_out;
   end
   // four time-outs of 8192 clocks and up to 15000 idle clocks make about 50000
   initial begin
      #700000;
      n_errors++;
      close_out;
   end
endmodule // tb_top
`default_nettype wire
